// file: shared/phy_bmc_params.svh
// Offsets, bit positions, reset values and timing for the mode control block
`ifndef PHY_BMC_PARAMS_SVH
`define PHY_BMC_PARAMS_SVH

`define BMC_OFFSET        5'h00
`define BMC_BIT_RESET     15
`define BMC_BIT_LOOPBACK  14
`define BMC_BIT_SPEED     13
`define BMC_BIT_ANEG_EN   12
`define BMC_BIT_PWRDN     11
`define BMC_BIT_ISOLATE   10
`define BMC_BIT_RESTART   9
`define BMC_BIT_DUPLEX    8
`define BMC_BIT_COLTEST   7
`define BMC_RESERVED_MASK 16'h007F
`define BMC_RESET_VALUE   16'h3100
`define BMC_SOFT_RESET_CYCLES 16
`define BMC_DEAD_TIME_MS  720
`define BMC_CLK_KHZ       20000
`define BMC_DEAD_CYCLES   (`BMC_DEAD_TIME_MS * `BMC_CLK_KHZ)

`endif

// file: shared/phy_bmc_pkg.sv
// Types for the basic mode control register block
`default_nettype none
package phy_bmc_pkg;
	// Management access request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} mgmt_req_t;

	// Negotiation outcome from the link engine
	typedef struct packed {
		logic speed_100;
		logic full_duplex;
	} aneg_result_t;

	// Control levels presented to the PHY core
	typedef struct packed {
		logic loopback;
		logic speed_100;
		logic aneg_en;
		logic power_down;
		logic isolate;
		logic full_duplex;
		logic col_test;
	} phy_ctrl_t;

	typedef enum logic [1:0] {
		RST_IDLE,
		RST_BUSY
	} soft_rst_state_t;
endpackage : phy_bmc_pkg
`default_nettype wire

// file: src/phy_bmc_sticky.sv
// Self-clearing control bit: set by write, held until the core acknowledges
`default_nettype none
module phy_bmc_sticky (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic set_i,
	input  wire logic done_i,
	output var  logic bit_o
);
	// Set wins over a completion arriving in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_o <= 1'b0;
		end else if (set_i) begin
			bit_o <= 1'b1;
		end else if (done_i) begin
			bit_o <= 1'b0;
		end
	end
endmodule : phy_bmc_sticky
`default_nettype wire

// file: src/phy_basic_mode_control.sv
// Basic mode control register of the embedded 10/100 PHY
`include "phy_bmc_params.svh"
`default_nettype none
module phy_basic_mode_control #(
	parameter int SOFT_RESET_CYCLES = `BMC_SOFT_RESET_CYCLES,
	parameter int DEAD_CYCLES       = `BMC_DEAD_CYCLES
) (
	input  wire logic                     clk_i,
	input  wire logic                     arst_n_i,
	input  wire phy_bmc_pkg::mgmt_req_t   req_i,
	input  wire phy_bmc_pkg::aneg_result_t aneg_i,
	input  wire logic                     aneg_started_i,
	input  wire logic                     tx_active_i,
	output var  logic [15:0]              rdata_o,
	output var  logic                     rvalid_o,
	output var  phy_bmc_pkg::phy_ctrl_t   ctrl_o,
	output var  logic                     aneg_restart_o,
	output var  logic                     soft_reset_o,
	output var  logic                     collision_o,
	output var  logic                     rx_blank_o
);
	// Refuse counts the 16-bit and 32-bit counters cannot serve
	if (SOFT_RESET_CYCLES < 1 || SOFT_RESET_CYCLES > 65535) begin : g_bad_rst
		$error("SOFT_RESET_CYCLES out of range");
	end
	if (DEAD_CYCLES < 1) begin : g_bad_dead
		$error("DEAD_CYCLES must be positive");
	end

	logic        rst_meta;
	logic        rst_n;
	logic        loopback;
	logic        speed_wr;
	logic        aneg_en;
	logic        pwrdn;
	logic        isolate;
	logic        duplex_wr;
	logic        col_test;
	logic        restart_bit;
	logic [15:0] rst_cnt;
	logic [31:0] dead_cnt;
	logic        loop_q;
	logic        hit_wr;
	logic        restart_set;
	logic        restart_clr;
	logic        speed_eff;
	logic        duplex_eff;
	logic [15:0] reg_view;
	phy_bmc_pkg::soft_rst_state_t rst_state;

	// Reset release through two flops
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	assign hit_wr = req_i.wr && (req_i.addr == `BMC_OFFSET);

	// Software reset sequencing
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rst_state <= phy_bmc_pkg::RST_IDLE;
			rst_cnt   <= 16'h0000;
		end else begin
			unique case (rst_state)
				phy_bmc_pkg::RST_IDLE: begin
					if (hit_wr && req_i.wdata[`BMC_BIT_RESET]) begin
						rst_state <= phy_bmc_pkg::RST_BUSY;
						rst_cnt   <= 16'(SOFT_RESET_CYCLES - 1);
					end
				end
				phy_bmc_pkg::RST_BUSY: begin
					if (rst_cnt == 16'h0000) begin
						rst_state <= phy_bmc_pkg::RST_IDLE;
					end else begin
						rst_cnt <= rst_cnt - 16'h0001;
					end
				end
			endcase
		end
	end

	// Read/write control bits; soft reset restores defaults
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			loopback  <= 1'b0;
			speed_wr  <= 1'b1;
			aneg_en   <= 1'b1;
			pwrdn     <= 1'b0;
			isolate   <= 1'b0;
			duplex_wr <= 1'b1;
			col_test  <= 1'b0;
		end else if (rst_state == phy_bmc_pkg::RST_BUSY) begin
			loopback  <= 1'b0;
			speed_wr  <= 1'b1;
			aneg_en   <= 1'b1;
			pwrdn     <= 1'b0;
			isolate   <= 1'b0;
			duplex_wr <= 1'b1;
			col_test  <= 1'b0;
		end else if (hit_wr && !req_i.wdata[`BMC_BIT_RESET]) begin
			loopback  <= req_i.wdata[`BMC_BIT_LOOPBACK];
			speed_wr  <= req_i.wdata[`BMC_BIT_SPEED];
			aneg_en   <= req_i.wdata[`BMC_BIT_ANEG_EN];
			pwrdn     <= req_i.wdata[`BMC_BIT_PWRDN];
			isolate   <= req_i.wdata[`BMC_BIT_ISOLATE];
			duplex_wr <= req_i.wdata[`BMC_BIT_DUPLEX];
			col_test  <= req_i.wdata[`BMC_BIT_COLTEST];
		end
	end

	// Restart only when negotiation is enabled; writing zero is ignored
	assign restart_set = hit_wr && !req_i.wdata[`BMC_BIT_RESET]
		&& req_i.wdata[`BMC_BIT_RESTART]
		&& req_i.wdata[`BMC_BIT_ANEG_EN]
		&& rst_state == phy_bmc_pkg::RST_IDLE;

	// Soft reset also returns a pending restart to its default
	assign restart_clr = aneg_started_i
		|| rst_state == phy_bmc_pkg::RST_BUSY;

	phy_bmc_sticky restart_flag (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.set_i   (restart_set),
		.done_i  (restart_clr),
		.bit_o   (restart_bit)
	);

	// Negotiated values override written ones while enabled
	assign speed_eff  = aneg_en ? aneg_i.speed_100 : speed_wr;
	assign duplex_eff = aneg_en ? aneg_i.full_duplex : duplex_wr;

	// Register view; reserved bits zero
	always_comb begin
		reg_view = 16'h0000;
		reg_view[`BMC_BIT_RESET]    = (rst_state == phy_bmc_pkg::RST_BUSY);
		reg_view[`BMC_BIT_LOOPBACK] = loopback;
		reg_view[`BMC_BIT_SPEED]    = speed_eff;
		reg_view[`BMC_BIT_ANEG_EN]  = aneg_en;
		reg_view[`BMC_BIT_PWRDN]    = pwrdn;
		reg_view[`BMC_BIT_ISOLATE]  = isolate;
		reg_view[`BMC_BIT_RESTART]  = restart_bit;
		reg_view[`BMC_BIT_DUPLEX]   = duplex_eff;
		reg_view[`BMC_BIT_COLTEST]  = col_test;
		reg_view = reg_view & ~`BMC_RESERVED_MASK;
	end

	// Read port answers even in power-down
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_o  <= 16'h0000;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= req_i.rd;
			rdata_o  <= (req_i.rd && req_i.addr == `BMC_OFFSET)
				? reg_view : 16'h0000;
		end
	end

	// Control outputs to the PHY core
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_o         <= '0;
			aneg_restart_o <= 1'b0;
			soft_reset_o   <= 1'b0;
			collision_o    <= 1'b0;
		end else begin
			ctrl_o.loopback    <= loopback;
			ctrl_o.speed_100   <= speed_eff;
			ctrl_o.aneg_en     <= aneg_en;
			ctrl_o.power_down  <= pwrdn;
			ctrl_o.isolate     <= isolate;
			ctrl_o.full_duplex <= duplex_eff;
			ctrl_o.col_test    <= col_test;
			aneg_restart_o     <= restart_bit && aneg_en;
			soft_reset_o       <= (rst_state == phy_bmc_pkg::RST_BUSY);
			collision_o        <= col_test && tx_active_i;
		end
	end

	// Receive dead time after loopback entry at 100 Mbps
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			loop_q     <= 1'b0;
			dead_cnt   <= 32'h0000_0000;
			rx_blank_o <= 1'b0;
		end else begin
			loop_q <= loopback;
			if (loopback && !loop_q && speed_eff) begin
				dead_cnt   <= 32'(DEAD_CYCLES);
				rx_blank_o <= 1'b1;
			end else if (dead_cnt != 32'h0000_0000) begin
				dead_cnt   <= dead_cnt - 32'h0000_0001;
				rx_blank_o <= (dead_cnt != 32'h0000_0001);
			end else begin
				rx_blank_o <= 1'b0;
			end
		end
	end
endmodule : phy_basic_mode_control
`default_nettype wire

// file: tb/link_engine_model.sv
// Link engine model: answers a restart request after a delay
`default_nettype none
module link_engine_model #(
	parameter int DLY = 4
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic restart_i,
	output var  logic started_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	// Pulse once per request, after DLY+1 cycles
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt       <= 0;
			started_o <= 1'b0;
		end else if (restart_i && !started_o) begin
			cnt       <= (cnt == DLY) ? 0 : cnt + 1;
			started_o <= (cnt == DLY);
		end else begin
			cnt       <= 0;
			started_o <= 1'b0;
		end
	end
endmodule : link_engine_model
`default_nettype wire

// file: tb/phy_bmc_props.sv
// Port checker for the basic mode control register
`default_nettype none
module phy_bmc_props (
	input wire logic                   clk_i,
	input wire logic                   arst_n_i,
	input wire phy_bmc_pkg::mgmt_req_t req_i,
	input wire logic                   tx_active_i,
	input wire logic [15:0]            rdata_o,
	input wire logic                   rvalid_o,
	input wire phy_bmc_pkg::phy_ctrl_t ctrl_o,
	input wire logic                   aneg_restart_o,
	input wire logic                   soft_reset_o,
	input wire logic                   collision_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	rd_answer_a: assert property (req_i.rd |=> rvalid_o)
		else $error("read not answered");
	rvalid_cause_a: assert property (rvalid_o |-> $past(req_i.rd))
		else $error("answer without read");
	reserved_zero_a: assert property (rvalid_o |-> !rdata_o[6:0])
		else $error("reserved bits set");
	coll_idle_a: assert property (!tx_active_i |=> !collision_o)
		else $error("collision outside transmit");
	restart_gate_a: assert property (aneg_restart_o |-> ctrl_o.aneg_en)
		else $error("restart without negotiation");
	srst_default_a: assert property (soft_reset_o [*3] |->
		{ctrl_o.loopback, ctrl_o.aneg_en, ctrl_o.power_down,
		ctrl_o.isolate, ctrl_o.col_test} == 5'h08)
		else $error("controls not default in reset");
	srst_bound_a: assert property (soft_reset_o |-> ##[1:40] !soft_reset_o)
		else $error("soft reset stuck");
	srst_read_a: assert property (req_i.rd && soft_reset_o ##1
		soft_reset_o |-> rdata_o[15])
		else $error("reset bit read low");
endmodule : phy_bmc_props
bind phy_basic_mode_control phy_bmc_props props_u (.clk_i(clk_i),
	.arst_n_i(arst_n_i), .req_i(req_i), .tx_active_i(tx_active_i),
	.rdata_o(rdata_o), .rvalid_o(rvalid_o), .ctrl_o(ctrl_o),
	.aneg_restart_o(aneg_restart_o), .soft_reset_o(soft_reset_o),
	.collision_o(collision_o));
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the basic mode control register
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                      clk_i, arst_n_i, tx_i, started;
	logic                      rvalid, restart, srst, coll, blank;
	logic [15:0]               rdata;
	phy_bmc_pkg::mgmt_req_t    req;
	phy_bmc_pkg::aneg_result_t aneg;
	phy_bmc_pkg::phy_ctrl_t    ctrl;
	int                        miscompares, comparisons;
	phy_basic_mode_control #(.SOFT_RESET_CYCLES(8), .DEAD_CYCLES(20)) dut_u (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .aneg_i(aneg),
		.aneg_started_i(started), .tx_active_i(tx_i), .rdata_o(rdata),
		.rvalid_o(rvalid), .ctrl_o(ctrl), .aneg_restart_o(restart),
		.soft_reset_o(srst), .collision_o(coll), .rx_blank_o(blank));
	link_engine_model #(.DLY(4)) link_u (.clk_i(clk_i), .rst_n_i(arst_n_i),
		.restart_i(restart), .started_o(started));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] d);
		@(posedge clk_i);
		req.wr <= 1'b1;
		req.addr <= 5'h00;
		req.wdata <= d;
		@(posedge clk_i);
		req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a);
		@(posedge clk_i);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge clk_i);
		req.rd <= 1'b0;
		#1;
		chk({15'h0000, rvalid}, 16'h0001);
	endtask : rd
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	// Reads until the masked bits clear, bounded
	task automatic poll(input logic [15:0] m);
		for (int i = 0; i < 40; i++) begin
			rd(5'h00);
			if ((rdata & m) === 16'h0000)
				return;
		end
		miscompares++;
		wrap_up();
	endtask : poll
	initial begin
		arst_n_i = 1'b0;
		req = '0;
		aneg = 2'b11;
		tx_i = 1'b0;
		miscompares = 0;
		comparisons = 0;
		repeat (4) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(5'h00);
		chk(rdata, 16'h3100);
		chk({9'h000, ctrl}, 16'h0032);
		@(posedge clk_i) aneg <= 2'b00;
		rd(5'h00);
		chk(rdata, 16'h1000);
		$display("defaults done");
		wr(16'h2B7F);
		rd(5'h00);
		chk(rdata, 16'h2900);
		chk({14'h0, restart, ctrl.power_down}, 16'h0001);
		rd(5'h01);
		chk(rdata, 16'h0000);
		$display("manual mode done");
		wr(16'h4080);
		@(posedge clk_i) tx_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1 chk({14'h0, coll, blank}, 16'h0002);
		rd(5'h00);
		chk(rdata, 16'h4080);
		chk({9'h000, ctrl}, 16'h0041);
		wr(16'h0000);
		wr(16'h6000);
		repeat (3) @(posedge clk_i);
		#1 chk({14'h0, coll, blank}, 16'h0001);
		repeat (17) @(posedge clk_i);
		#1 chk({15'h0, blank}, 16'h0001);
		repeat (13) @(posedge clk_i);
		#1 chk({15'h0, blank}, 16'h0000);
		$display("loopback done");
		wr(16'h1200);
		rd(5'h00);
		chk(rdata, 16'h1200);
		chk({15'h0, restart}, 16'h0001);
		poll(16'h0200);
		$display("restart done");
		wr(16'h5A80);
		wr(16'h8000);
		rd(5'h00);
		chk(rdata & 16'h8200, 16'h8000);
		chk({15'h0, srst}, 16'h0001);
		poll(16'h8000);
		rd(5'h00);
		chk(rdata, 16'h1000);
		chk({9'h000, ctrl}, 16'h0010);
		chk({15'h0, srst}, 16'h0000);
		$display("soft reset done");
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
